// file: inc/cam_link_rx_defines.svh
// Constants for the camera video link receiver: widths, bit positions, serial timing
`ifndef CAM_LINK_RX_DEFINES_SVH
`define CAM_LINK_RX_DEFINES_SVH
`define LINK_BITS 28
`define PORT_BITS 8
`define PORT_COUNT 8
`define LINK_COUNT 3
`define LINK_DATA_BITS 24
`define EN_FRAME 24
`define EN_LINE 25
`define EN_DATA 26
`define EN_SPARE 27
`define CLK_HZ 20000000
`define BAUD_RATE 9600
`define BAUD_CYCLES ((`CLK_HZ) / (`BAUD_RATE))
`define HALF_BAUD_CYCLES ((`BAUD_CYCLES) / 2)
`define SER_DATA_BITS 8
`define FIFO_DEPTH 8
`endif

// file: inc/cam_link_rx_pkg.sv
// Types shared by the camera video link receiver
package cam_link_rx_pkg;
  typedef enum logic [1:0] {
    CfgBase = 2'h0,
    CfgMedium = 2'h1,
    CfgFull = 2'h2
  } link_cfg_t;
  typedef enum logic [1:0] {
    SerIdle = 2'h0,
    SerStart = 2'h1,
    SerData = 2'h3,
    SerStop = 2'h2
  } ser_state_t;
endpackage

// file: rtl/pixel_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int Width = 64,
  parameter int Depth = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int AW = (Depth > 1) ? $clog2(Depth) : 1;

  // Elaboration check: the wrap-bit full test only works for power-of-two depths
  if (Depth < 2 || (1 << AW) != Depth) begin : g_depth_check
    $error("pixel_fifo depth must be a power of two, at least 2");
  end

  logic [Width-1:0] mem_q [Depth];
  logic [Width-1:0] mem_d [Depth];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // Full when pointers differ only in the wrap bit
  assign inReady = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign outValid = (wr_q != rd_q);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_q[rd_q[AW-1:0]];

  // Next pointers and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q[AW-1:0]] = inData;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < Depth; i++) mem_q[i] <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/camera_video_link_receiver.sv
// Frame-grabber end of a camera video link: pixel capture, camera controls, serial port
`timescale 1ns/1ps
`default_nettype none
`include "cam_link_rx_defines.svh"

// What this block does
// - Each link carries at most 28 bits per transfer; wider cameras use more links.
// - Base uses one link, medium two and full three, chosen by the configuration input.
// - Every video port is handled as an 8-bit byte.
// - In full configuration eight byte ports A to H are captured.
// - The fourth enable bit is spare and is ignored by the receiver.
// - The grabber drives four camera control lines as outputs.
// - One serial line runs camera to grabber and one grabber to camera.
// - The serial port runs at 9600 baud.
// - Serial characters have one start bit, one stop bit, no parity and no flow control.
module camera_video_link_receiver
  import cam_link_rx_pkg::*;
#(
  parameter int BaudCycles = `BAUD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link side, already deserialized, timed by the link clock
  input wire logic linkClk,
  input wire logic [`LINK_BITS-1:0] linkX,
  input wire logic [`LINK_BITS-1:0] linkY,
  input wire logic [`LINK_BITS-1:0] linkZ,
  // Configuration
  input wire link_cfg_t linkCfg,
  // Pixel output stream
  output logic pixValid,
  input wire logic pixReady,
  output logic [`PORT_COUNT*`PORT_BITS-1:0] pixData,
  output logic [3:0] pixPortMask,
  output logic frameActive,
  output logic pixOverflow,
  // Camera control lines
  input wire logic [3:0] camCtrlIn,
  output logic cam_ctrl_1,
  output logic cam_ctrl_2,
  output logic cam_ctrl_3,
  output logic cam_ctrl_4,
  // Serial transmit request
  input wire logic txValid,
  output logic txReady,
  input wire logic [`SER_DATA_BITS-1:0] txByte,
  // Serial receive result
  output logic rxValid,
  output logic [`SER_DATA_BITS-1:0] rxByte,
  output logic rxFrameErr,
  // Serial pins
  input wire logic serial_to_grabber,
  output logic serial_to_camera
);
  localparam int FW = `PORT_COUNT * `PORT_BITS;
  localparam int CW = $clog2(BaudCycles + 1);
  localparam logic [CW-1:0] BaudMax = CW'(BaudCycles - 1);
  localparam logic [CW-1:0] HalfMax = CW'(BaudCycles / 2 - 1);

  // Elaboration check: the half-bit counter needs a few cycles per bit
  if (BaudCycles < 4) begin : g_baud_check
    $error("BaudCycles too small");
  end

  // Two-flop synchronisers for everything from the link and the serial pin
  logic [3*`LINK_BITS:0] syn1_q, syn2_q, syn1_d;
  logic linkClkPrev_q, linkClkPrev_d;
  logic rxS1_q, rxS2_q;
  assign syn1_d = {linkClk, linkZ, linkY, linkX};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syn1_q <= '0;
      syn2_q <= '0;
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
      linkClkPrev_q <= 1'b0;
    end else begin
      syn1_q <= syn1_d;
      syn2_q <= syn1_q;
      rxS1_q <= serial_to_grabber;
      rxS2_q <= rxS1_q;
      linkClkPrev_q <= linkClkPrev_d;
    end
  end

  // Word decode on each rising edge of the sampled link clock
  logic [`LINK_BITS-1:0] wX, wY, wZ;
  logic linkRise, capture;
  logic [FW-1:0] word;
  logic [3:0] mask;
  logic fifoReady;
  assign wX = syn2_q[`LINK_BITS-1:0];
  assign wY = syn2_q[2*`LINK_BITS-1:`LINK_BITS];
  assign wZ = syn2_q[3*`LINK_BITS-1:2*`LINK_BITS];
  assign linkClkPrev_d = syn2_q[3*`LINK_BITS];
  assign linkRise = syn2_q[3*`LINK_BITS] && !linkClkPrev_q;
  // Enables come from link X; spare bit 27 is never read
  assign capture = linkRise && wX[`EN_FRAME] && wX[`EN_LINE] && wX[`EN_DATA];
  assign frameActive = wX[`EN_FRAME];

  // Pack bytes A..H; unused links contribute zero whatever the camera sends
  always_comb begin
    word = '0;
    mask = 4'h0;
    word[`LINK_DATA_BITS-1:0] = wX[`LINK_DATA_BITS-1:0];
    mask = 4'h1;
    unique case (linkCfg)
      CfgMedium: begin
        word[2*`LINK_DATA_BITS-1:`LINK_DATA_BITS] = wY[`LINK_DATA_BITS-1:0];
        mask = 4'h3;
      end
      CfgFull: begin
        word[2*`LINK_DATA_BITS-1:`LINK_DATA_BITS] = wY[`LINK_DATA_BITS-1:0];
        word[FW-1:2*`LINK_DATA_BITS] = wZ[FW-2*`LINK_DATA_BITS-1:0];
        mask = 4'h7;
      end
      default: begin
        mask = 4'h1;
      end
    endcase
  end

  // Overflow is sticky until the next frame starts; the link cannot be stalled
  logic ovf_q, ovf_d, frPrev_q, frPrev_d;
  assign frPrev_d = wX[`EN_FRAME];
  always_comb begin
    ovf_d = ovf_q;
    if (wX[`EN_FRAME] && !frPrev_q) ovf_d = 1'b0;
    if (capture && !fifoReady) ovf_d = 1'b1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
      frPrev_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
      frPrev_q <= frPrev_d;
    end
  end
  assign pixOverflow = ovf_q;

  logic [FW+3:0] fifoOut;
  pixel_fifo #(
    .Width(FW + 4),
    .Depth(`FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(capture),
    .inReady(fifoReady),
    .inData({mask, word}),
    .outValid(pixValid),
    .outReady(pixReady),
    .outData(fifoOut)
  );
  assign pixData = fifoOut[FW-1:0];
  assign pixPortMask = fifoOut[FW+3:FW];

  // Camera control lines from registers
  logic [3:0] cc_q, cc_d;
  assign cc_d = camCtrlIn;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cc_q <= 4'h0;
    else cc_q <= cc_d;
  end
  assign cam_ctrl_1 = cc_q[0];
  assign cam_ctrl_2 = cc_q[1];
  assign cam_ctrl_3 = cc_q[2];
  assign cam_ctrl_4 = cc_q[3];

  // Serial transmitter: start, 8 data LSB first, stop; no parity or flow control
  ser_state_t txSt_q, txSt_d;
  logic [CW-1:0] txCnt_q, txCnt_d;
  logic [2:0] txBit_q, txBit_d;
  logic [7:0] txSh_q, txSh_d;
  logic txLine_q, txLine_d;
  assign txReady = (txSt_q == SerIdle);
  always_comb begin
    txSt_d = txSt_q;
    txCnt_d = txCnt_q;
    txBit_d = txBit_q;
    txSh_d = txSh_q;
    txLine_d = txLine_q;
    unique case (txSt_q)
      SerIdle: begin
        txLine_d = 1'b1;
        if (txValid) begin
          txSh_d = txByte;
          txLine_d = 1'b0;
          txCnt_d = BaudMax;
          txSt_d = SerStart;
        end
      end
      SerStart: begin
        if (txCnt_q == '0) begin
          txLine_d = txSh_q[0];
          txSh_d = {1'b0, txSh_q[7:1]};
          txBit_d = 3'h0;
          txCnt_d = BaudMax;
          txSt_d = SerData;
        end else txCnt_d = txCnt_q - 1'b1;
      end
      SerData: begin
        if (txCnt_q == '0) begin
          txCnt_d = BaudMax;
          if (txBit_q == 3'h7) begin
            txLine_d = 1'b1;
            txSt_d = SerStop;
          end else begin
            txLine_d = txSh_q[0];
            txSh_d = {1'b0, txSh_q[7:1]};
            txBit_d = txBit_q + 3'h1;
          end
        end else txCnt_d = txCnt_q - 1'b1;
      end
      SerStop: begin
        if (txCnt_q == '0) txSt_d = SerIdle;
        else txCnt_d = txCnt_q - 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txSt_q <= SerIdle;
      txCnt_q <= '0;
      txBit_q <= 3'h0;
      txSh_q <= 8'h00;
      txLine_q <= 1'b1;
    end else begin
      txSt_q <= txSt_d;
      txCnt_q <= txCnt_d;
      txBit_q <= txBit_d;
      txSh_q <= txSh_d;
      txLine_q <= txLine_d;
    end
  end
  assign serial_to_camera = txLine_q;

  // Serial receiver: samples mid-bit; a low stop bit flags a framing error
  ser_state_t rxSt_q, rxSt_d;
  logic [CW-1:0] rxCnt_q, rxCnt_d;
  logic [2:0] rxBit_q, rxBit_d;
  logic [7:0] rxSh_q, rxSh_d, rxByte_q, rxByte_d;
  logic rxV_q, rxV_d, rxE_q, rxE_d;
  always_comb begin
    rxSt_d = rxSt_q;
    rxCnt_d = rxCnt_q;
    rxBit_d = rxBit_q;
    rxSh_d = rxSh_q;
    rxByte_d = rxByte_q;
    rxV_d = 1'b0;
    rxE_d = 1'b0;
    unique case (rxSt_q)
      SerIdle: begin
        if (!rxS2_q) begin
          rxCnt_d = HalfMax;
          rxSt_d = SerStart;
        end
      end
      SerStart: begin
        if (rxCnt_q == '0) begin
          // A start bit gone high by mid-bit was a glitch
          rxSt_d = rxS2_q ? SerIdle : SerData;
          rxCnt_d = BaudMax;
          rxBit_d = 3'h0;
        end else rxCnt_d = rxCnt_q - 1'b1;
      end
      SerData: begin
        if (rxCnt_q == '0) begin
          rxSh_d = {rxS2_q, rxSh_q[7:1]};
          rxCnt_d = BaudMax;
          if (rxBit_q == 3'h7) rxSt_d = SerStop;
          else rxBit_d = rxBit_q + 3'h1;
        end else rxCnt_d = rxCnt_q - 1'b1;
      end
      SerStop: begin
        if (rxCnt_q == '0) begin
          rxByte_d = rxSh_q;
          rxV_d = rxS2_q;
          rxE_d = !rxS2_q;
          rxSt_d = SerIdle;
        end else rxCnt_d = rxCnt_q - 1'b1;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxSt_q <= SerIdle;
      rxCnt_q <= '0;
      rxBit_q <= 3'h0;
      rxSh_q <= 8'h00;
      rxByte_q <= 8'h00;
      rxV_q <= 1'b0;
      rxE_q <= 1'b0;
    end else begin
      rxSt_q <= rxSt_d;
      rxCnt_q <= rxCnt_d;
      rxBit_q <= rxBit_d;
      rxSh_q <= rxSh_d;
      rxByte_q <= rxByte_d;
      rxV_q <= rxV_d;
      rxE_q <= rxE_d;
    end
  end
  assign rxValid = rxV_q;
  assign rxByte = rxByte_q;
  assign rxFrameErr = rxE_q;
endmodule
`default_nettype wire

// file: dv/cam_link_rx_properties.sv
// Checker on the receiver's ports: control lines, serial framing, pixel stream
`timescale 1ns/1ps
`default_nettype none
`include "cam_link_rx_defines.svh"
module cam_link_rx_checker #(
  parameter int BaudCycles = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Controls and serial
  input wire logic [3:0] camCtrlIn,
  input wire logic cam_ctrl_1,
  input wire logic cam_ctrl_2,
  input wire logic cam_ctrl_3,
  input wire logic cam_ctrl_4,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [`SER_DATA_BITS-1:0] txByte,
  input wire logic rxValid,
  input wire logic rxFrameErr,
  input wire logic serial_to_grabber,
  input wire logic serial_to_camera,
  // Pixel stream
  input wire logic pixValid,
  input wire logic pixReady,
  input wire logic [`PORT_COUNT*`PORT_BITS-1:0] pixData,
  input wire logic [3:0] pixPortMask
);
  // The literal 8s below assume the bench's eight-cycle bit
  localparam int FrameLo = 10 * BaudCycles;
  localparam int FrameHi = FrameLo + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence startBit;
    !serial_to_camera [*8];
  endsequence
  sequence stopBit;
    serial_to_camera [*8];
  endsequence
  a_ctrl_follow: assert property ($past(nrst) |-> {cam_ctrl_4, cam_ctrl_3, cam_ctrl_2, cam_ctrl_1} == $past(camCtrlIn))
    else $error("control lines do not follow request");
  a_tx_frame: assert property (txValid && txReady |=> startBit ##65 stopBit)
    else $error("transmit framing wrong");
  a_tx_first_bit: assert property (txValid && txReady |-> ##9 (serial_to_camera == $past(txByte[0], 9)) ##1 $stable(serial_to_camera) [*7])
    else $error("first data bit not the lsb");
  a_tx_ready_back: assert property (txValid && txReady |-> ##[FrameLo:FrameHi] txReady)
    else $error("transmitter not idle again in time");
  a_tx_idle_high: assert property (txReady |-> serial_to_camera)
    else $error("idle serial line not high");
  a_rx_one_pulse: assert property (rxValid || rxFrameErr |-> !(rxValid && rxFrameErr) ##1 !(rxValid || rxFrameErr))
    else $error("receive pulse malformed");
  a_rx_stop_good: assert property (rxValid |-> $past(serial_to_grabber, 3))
    else $error("byte accepted with low stop bit");
  a_rx_stop_bad: assert property (rxFrameErr |-> !$past(serial_to_grabber, 3))
    else $error("framing error with high stop bit");
  a_pix_hold: assert property (pixValid && !pixReady |=> pixValid && $stable(pixData))
    else $error("stalled pixel word changed");
  a_mask_legal: assert property (pixValid |-> pixPortMask inside {4'h1, 4'h3, 4'h7})
    else $error("illegal link mask");
  a_unused_zero: assert property (pixValid |-> (pixPortMask[2] || pixData[63:48] == 16'h0) && (pixPortMask[1] || pixData[47:24] == 24'h0))
    else $error("unused ports not zero");
endmodule
bind camera_video_link_receiver cam_link_rx_checker #(.BaudCycles(BaudCycles)) chk (.clk(clk), .nrst(nrst),
  .camCtrlIn(camCtrlIn), .cam_ctrl_1(cam_ctrl_1), .cam_ctrl_2(cam_ctrl_2), .cam_ctrl_3(cam_ctrl_3),
  .cam_ctrl_4(cam_ctrl_4), .txValid(txValid), .txReady(txReady), .txByte(txByte), .rxValid(rxValid),
  .rxFrameErr(rxFrameErr), .serial_to_grabber(serial_to_grabber), .serial_to_camera(serial_to_camera),
  .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData), .pixPortMask(pixPortMask));
`default_nettype wire

// file: dv/camera_model.sv
// Behavioural camera: link beats, serial characters out, decoder for characters in
`timescale 1ns/1ps
`default_nettype none
module camera_model (
  // Link side
  output logic linkClk,
  output logic [27:0] linkX,
  output logic [27:0] linkY,
  output logic [27:0] linkZ,
  // Serial lines
  output logic serial_to_grabber,
  input wire logic serial_to_camera
);
  logic [7:0] gotQ[$];
  logic [7:0] sh;
  // Link clock stands still low between beats
  initial begin
    linkClk = 1'b0;
    linkX = '0;
    linkY = '0;
    linkZ = '0;
    serial_to_grabber = 1'b1;
  end
  // One 400 ns beat; data changes only while the clock is low
  task beat(input logic [3:0] en, input logic [63:0] d);
    linkX = {en, d[23:0]};
    linkY = {en, d[47:24]};
    linkZ = {en, 8'h00, d[63:48]};
    #200 linkClk = 1'b1;
    #200 linkClk = 1'b0;
  endtask
  // One character at eight clocks a bit; a low stop bit only when asked
  task sendByte(input logic [7:0] b, input logic good);
    serial_to_grabber = 1'b0;
    for (int i = 0; i < 8; i++) #400 serial_to_grabber = b[i];
    #400 serial_to_grabber = good;
    #400 serial_to_grabber = 1'b1;
    #400;
  endtask
  // Samples the grabber's characters at mid bit; a low stop bit drops them
  always @(negedge serial_to_camera) begin
    #200;
    if (!serial_to_camera) begin
      for (int i = 0; i < 8; i++) #400 sh[i] = serial_to_camera;
      #400 if (serial_to_camera) gotQ.push_back(sh);
    end
  end
endmodule
`default_nettype wire

// file: dv/camera_video_link_receiver_bench.sv
// Self-checking bench for the camera link receiver
`timescale 1ns/1ps
`default_nettype none
module camera_video_link_receiver_bench
  import cam_link_rx_pkg::*;
;
  logic clk, nrst, linkClk, pixValid, pixReady, frameActive, pixOverflow;
  logic txValid, txReady, rxValid, rxFrameErr, serial_to_grabber, serial_to_camera, c1, c2, c3, c4;
  logic [27:0] linkX, linkY, linkZ;
  logic [63:0] pixData;
  logic [3:0] pixPortMask, camCtrlIn;
  logic [7:0] txByte, rxByte;
  link_cfg_t linkCfg;
  logic [67:0] expQ[$];
  logic [7:0] sentQ[$];
  int mismatches = 0;
  int check_count = 0;
  camera_video_link_receiver #(.BaudCycles(8)) uut (.clk(clk), .nrst(nrst), .linkClk(linkClk), .linkX(linkX),
    .linkY(linkY), .linkZ(linkZ), .linkCfg(linkCfg), .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
    .pixPortMask(pixPortMask), .frameActive(frameActive), .pixOverflow(pixOverflow), .camCtrlIn(camCtrlIn),
    .cam_ctrl_1(c1), .cam_ctrl_2(c2), .cam_ctrl_3(c3), .cam_ctrl_4(c4), .txValid(txValid), .txReady(txReady),
    .txByte(txByte), .rxValid(rxValid), .rxByte(rxByte), .rxFrameErr(rxFrameErr),
    .serial_to_grabber(serial_to_grabber), .serial_to_camera(serial_to_camera));
  camera_model cam (.linkClk(linkClk), .linkX(linkX), .linkY(linkY), .linkZ(linkZ),
    .serial_to_grabber(serial_to_grabber), .serial_to_camera(serial_to_camera));
  task check(input logic [67:0] seen, input logic [67:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One link beat; the model keeps the word only when all three enables are high
  task beat(input logic [3:0] en);
    logic [63:0] d;
    logic [3:0] m;
    d = {$urandom, $urandom};
    m = linkCfg == CfgFull ? 4'h7 : linkCfg == CfgMedium ? 4'h3 : 4'h1;
    if (en[2:0] == 3'h7) expQ.push_back({m, d & {{16{m[2]}}, {24{m[1]}}, 24'hffffff}});
    cam.beat(en, d);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Every popped word must be the oldest expected one
  always @(posedge clk) begin
    if (pixValid === 1'b1 && pixReady === 1'b1) begin
      if (expQ.size() == 0) check({pixPortMask, pixData}, {4'hf, 64'h0});
      else check({pixPortMask, pixData}, expQ.pop_front());
    end
  end
  // Cuts a hang short well beyond the expected run
  initial begin
    #400us;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] b;
    void'($urandom(82));
    nrst = 1'b0;
    linkCfg = CfgBase;
    pixReady = 1'b0;
    camCtrlIn = 4'h0;
    txValid = 1'b0;
    txByte = 8'h00;
    repeat (8) @(posedge clk);
    #5 nrst = 1'b1;
    check(serial_to_camera, 1'b1);
    repeat (4) begin
      @(posedge clk);
      #5 camCtrlIn = 4'($urandom);
      @(posedge clk);
      #5 check({c4, c3, c2, c1}, camCtrlIn);
    end
    // Every configuration code, spare bit random, sink stalling at random
    for (int c = 0; c < 4; c++) begin
      linkCfg = link_cfg_t'(c);
      repeat (12) begin
        pixReady = 1'($urandom);
        beat(4'($urandom) | {1'b0, {3{1'($urandom)}}});
      end
    end
    pixReady = 1'b1;
    repeat (20) @(posedge clk);
    #5;
    check(expQ.size(), 0);
    // Overfill the buffer inside one frame, then drain it
    pixReady = 1'b0;
    beat(4'h0);
    repeat (9) beat(4'h7);
    void'(expQ.pop_back());
    repeat (2) @(posedge clk);
    #5;
    check({frameActive, pixOverflow}, 2'b11);
    pixReady = 1'b1;
    repeat (20) @(posedge clk);
    #5;
    check({expQ.size(), pixValid}, 0);
    beat(4'h0);
    beat(4'h1);
    repeat (4) @(posedge clk);
    #5;
    check(pixOverflow, 1'b0);
    // Two characters back to back to the camera
    txValid = 1'b1;
    repeat (2) begin
      txByte = 8'($urandom);
      for (int i = 0; i < 200 && txReady !== 1'b1; i++) begin
        @(posedge clk);
        #5;
      end
      @(posedge clk);
      sentQ.push_back(txByte);
      #5;
    end
    txValid = 1'b0;
    repeat (200) @(posedge clk);
    #5;
    check(cam.gotQ.size(), 2);
    while (cam.gotQ.size() > 0) check(cam.gotQ.pop_front(), sentQ.pop_front());
    // Characters from the camera, good stop bit then low stop bit
    for (int g = 0; g < 2; g++) begin
      b = 8'($urandom);
      fork
        cam.sendByte(b, 1'(1 - g));
        begin
          for (int i = 0; i < 200 && rxValid !== 1'b1 && rxFrameErr !== 1'b1; i++) begin
            @(posedge clk);
            #5;
          end
          check({rxValid, rxFrameErr}, g ? 2'b01 : 2'b10);
          if (g == 0) check(rxByte, b);
        end
      join
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
